// >>> include/scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SCP_NUM_REGS 32
`define SCP_SLOT_W 64
`define SCP_CTRL_ONE_ADDR 5'h00
`define SCP_CTRL_TWO_ADDR 5'h01
`define SCP_PROF_FIRST 5'h0E
`define SCP_PROF_LAST 5'h15
`define SCP_CTRL_RESET 64'h0000_0000_0000_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCP_LSB_FIRST_BIT 0
`define SCP_INPUT_ONLY_BIT 1
`define SCP_RW_BIT 7
`define SCP_ADDR_MSB 4

// ----------------------------------------
// Counts
// ----------------------------------------
`define SCP_BYTE_LAST 3'h7
`define SCP_SHORT_LAST 3'h3
`define SCP_LONG_LAST 3'h7
`define SCP_IDX_SHORT 6'h1F
`define SCP_IDX_LONG 6'h3F
`define SCP_IDX_STEP 6'h01
`define SCP_CNT_STEP 3'h1

`endif

// >>> include/scp_pkg.sv
package scp_pkg;
`include "scp_defs.svh"

    typedef enum logic [1:0] {
        SCP_INSTR,
        SCP_WRITE,
        SCP_READ
    } scp_phase_t;

    typedef struct packed {
        logic [7:0] stage1;
        logic [7:0] stage2;
    } scp_sync_t;

    typedef struct packed {
        scp_phase_t phase;
        logic [2:0] bitCnt;
        logic [2:0] byteCnt;
        logic [2:0] lastByte;
        logic [7:0] shiftReg;
        logic [4:0] addr;
        logic [5:0] readIdx;
        logic [`SCP_SLOT_W-1:0] readData;
        logic dataOut;
        logic driving;
        logic sclkPrev;
        logic updatePrev;
        logic [2:0] profilePrev;
        logic [`SCP_NUM_REGS-1:0][`SCP_SLOT_W-1:0] staging;
        logic [`SCP_NUM_REGS-1:0][`SCP_SLOT_W-1:0] active;
    } scp_core_t;

endpackage : scp_pkg

// >>> include/scp_sync_if.sv
`timescale 1ns/100ps
interface scp_sync_if;
    logic sclkS;
    logic csNS;
    logic sdiS;
    logic ioResetS;
    logic ioUpdateS;
    logic [2:0] profileS;

    modport src (output sclkS, output csNS, output sdiS, output ioResetS, output ioUpdateS, output profileS);
    modport dst (input sclkS, input csNS, input sdiS, input ioResetS, input ioUpdateS, input profileS);
endinterface : scp_sync_if

// >>> design/scp_pin_sync.sv
`timescale 1ns/100ps
module scp_pin_sync
    import scp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdioIn,
    input wire logic ioReset,
    input wire logic ioUpdate,
    input wire logic [2:0] profile,
    scp_sync_if.src syncOut
);
    scp_sync_t sync_reg;
    scp_sync_t sync_next;

    // ----------------------------------------
    // Two-stage capture of all host pins
    // ----------------------------------------
    always_comb begin
        sync_next = sync_reg;
        sync_next.stage1 = {sclk, csN, sdioIn, ioReset, ioUpdate, profile};
        sync_next.stage2 = sync_reg.stage1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign {syncOut.sclkS, syncOut.csNS, syncOut.sdiS, syncOut.ioResetS, syncOut.ioUpdateS,
            syncOut.profileS} = sync_reg.stage2;
endmodule : scp_pin_sync

// >>> design/scp_serial_config_port.sv
// Functional notes
// - A cycle is one instruction byte then a data phase writing or reading.
// - Data byte count equals addressed register length; address 0x01 takes four.
// - Write data bits are captured on rising serial clock edges.
// - Abort ends the transfer; next byte is an instruction byte.
// - Completed bytes stay staged on abort; partial byte is dropped.
// - After any cycle the next eight rising edges form an instruction.
// - Written data stays staged until a commit copies it to active.
// - A change on the profile pins also commits staged data.
// - Reads return active register contents, not staged ones.
// - Read data bits are driven on falling serial clock edges.
// - Profile register writes ignore the profile pins.
// - Bit order is MSB first or LSB first by configuration.
// - Two-wire mode uses one bidirectional pin; three-wire uses separate output.
// - Instruction bit 7 is read when set; bits 4..0 are address.
// - Select high floats outputs and suspends the cycle in progress.
// - Commit acts on its rising edge; pulse wider than one clock.
`timescale 1ns/100ps
`include "scp_defs.svh"
module scp_serial_config_port
    import scp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOe,
    output logic serialDataOutPinOut,
    output logic serialDataOutPinOe,
    input wire logic ioReset,
    input wire logic ioUpdate,
    input wire logic [2:0] profile,
    output logic [31:0] activeControlFunctionTwo
);
    scp_sync_if syncBus ();

    scp_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .sclk(sclk),
        .csN(csN),
        .sdioIn(sdioIn),
        .ioReset(ioReset),
        .ioUpdate(ioUpdate),
        .profile(profile),
        .syncOut(syncBus)
    );

    scp_core_t core_reg;
    scp_core_t core_next;

    logic sclkRise;
    logic sclkFall;
    logic lsbFirst;
    logic inputOnly;
    logic byteDone;
    logic commit;
    logic [7:0] newByte;
    logic [4:0] newAddr;
    logic [4:0] readAddr;
    logic [2:0] newLast;
    logic [2:0] slot;

    // ----------------------------------------
    // Edge detection and decode
    // ----------------------------------------
    // Serial clock is oversampled, so it must stay well below a quarter of clk
    assign sclkRise = syncBus.sclkS & ~core_reg.sclkPrev;
    assign sclkFall = ~syncBus.sclkS & core_reg.sclkPrev;
    assign lsbFirst = core_reg.active[`SCP_CTRL_ONE_ADDR][`SCP_LSB_FIRST_BIT];
    assign inputOnly = core_reg.active[`SCP_CTRL_ONE_ADDR][`SCP_INPUT_ONLY_BIT];
    assign byteDone = (core_reg.bitCnt == `SCP_BYTE_LAST);
    assign newByte = lsbFirst ? {syncBus.sdiS, core_reg.shiftReg[7:1]}
                              : {core_reg.shiftReg[6:0], syncBus.sdiS};
    assign newAddr = newByte[`SCP_ADDR_MSB:0];
    // Profile registers stretch to eight bytes, all others four
    assign newLast = (newAddr >= `SCP_PROF_FIRST && newAddr <= `SCP_PROF_LAST) ? `SCP_LONG_LAST
                                                                             : `SCP_SHORT_LAST;
    // Profile reads follow the pins, not the instruction index
    assign readAddr = (newAddr >= `SCP_PROF_FIRST && newAddr <= `SCP_PROF_LAST)
                      ? 5'(`SCP_PROF_FIRST + {2'b00, syncBus.profileS}) : newAddr;
    assign slot = lsbFirst ? core_reg.byteCnt : 3'(core_reg.lastByte - core_reg.byteCnt);
    assign commit = (syncBus.ioUpdateS & ~core_reg.updatePrev)
                    | (syncBus.profileS != core_reg.profilePrev);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        core_next = core_reg;
        core_next.sclkPrev = syncBus.sclkS;
        core_next.updatePrev = syncBus.ioUpdateS;
        core_next.profilePrev = syncBus.profileS;
        // Abort wins over select so a host can resync a suspended cycle
        if (syncBus.ioResetS) begin
            // Partial byte lost, completed bytes already staged
            core_next.phase = SCP_INSTR;
            core_next.bitCnt = '0;
            core_next.byteCnt = '0;
        end else if (syncBus.csNS) begin
            core_next.sclkPrev = core_reg.sclkPrev;
        end else begin
            if (sclkRise) begin
                core_next.bitCnt = core_reg.bitCnt + `SCP_CNT_STEP;
                case (core_reg.phase)
                    SCP_INSTR: begin
                        core_next.shiftReg = newByte;
                        if (byteDone) begin
                            core_next.addr = newAddr;
                            core_next.lastByte = newLast;
                            core_next.byteCnt = '0;
                            if (newByte[`SCP_RW_BIT]) begin
                                core_next.phase = SCP_READ;
                                core_next.readData = core_reg.active[readAddr];
                                core_next.readIdx = lsbFirst ? '0
                                    : (newLast == `SCP_LONG_LAST ? `SCP_IDX_LONG : `SCP_IDX_SHORT);
                            end else begin
                                core_next.phase = SCP_WRITE;
                            end
                        end
                    end
                    SCP_WRITE: begin
                        core_next.shiftReg = newByte;
                        if (byteDone) begin
                            // Profile writes go straight to their own slot
                            core_next.staging[core_reg.addr][{slot, 3'b000} +: 8] = newByte;
                            core_next.byteCnt = core_reg.byteCnt + `SCP_CNT_STEP;
                            if (core_reg.byteCnt == core_reg.lastByte) begin
                                core_next.phase = SCP_INSTR;
                            end
                        end
                    end
                    SCP_READ: begin
                        core_next.readIdx = lsbFirst ? core_reg.readIdx + `SCP_IDX_STEP
                                                     : core_reg.readIdx - `SCP_IDX_STEP;
                        if (byteDone) begin
                            core_next.byteCnt = core_reg.byteCnt + `SCP_CNT_STEP;
                            if (core_reg.byteCnt == core_reg.lastByte) begin
                                core_next.phase = SCP_INSTR;
                            end
                        end
                    end
                    default: begin
                        core_next.phase = SCP_INSTR;
                    end
                endcase
            end
            if (sclkFall && core_reg.phase == SCP_READ) begin
                core_next.dataOut = core_reg.readData[core_reg.readIdx];
                core_next.driving = 1'b1;
            end
        end
        if (core_next.phase != SCP_READ) begin
            core_next.driving = 1'b0;
        end
        if (commit) begin
            core_next.active = core_next.staging;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    // Drive starts at the first falling edge so a two-wire host has time to release
    assign sdioOut = core_reg.dataOut;
    assign sdioOe = core_reg.driving & ~syncBus.csNS & ~inputOnly;
    assign serialDataOutPinOut = core_reg.dataOut;
    assign serialDataOutPinOe = core_reg.driving & ~syncBus.csNS & inputOnly;
    assign activeControlFunctionTwo = core_reg.active[`SCP_CTRL_TWO_ADDR][31:0];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic instrEnd;
    assign instrEnd = sclkRise & ~syncBus.csNS & ~syncBus.ioResetS & byteDone & (core_reg.phase == SCP_INSTR);

    write_decode_a: assert property (instrEnd && !newByte[`SCP_RW_BIT]
        |=> core_reg.phase == SCP_WRITE && core_reg.addr == $past(newAddr))
        else $error("write instruction not decoded");
    read_decode_a: assert property (instrEnd && newByte[`SCP_RW_BIT]
        |=> core_reg.phase == SCP_READ && core_reg.readData == $past(core_reg.active[readAddr]))
        else $error("read did not load active contents");
    abort_pointer_a: assert property (syncBus.ioResetS
        |=> core_reg.phase == SCP_INSTR && core_reg.bitCnt == '0 && core_reg.byteCnt == '0)
        else $error("abort did not reset pointer");
    commit_copy_a: assert property (commit |=> core_reg.active == core_reg.staging)
        else $error("commit did not copy staging");
    active_hold_a: assert property (!commit |=> $stable(core_reg.active))
        else $error("active changed without commit");
    profile_commit_a: assert property (!$stable(syncBus.profileS)
        |=> core_reg.active == $past(core_next.staging))
        else $error("profile change did not commit");
    select_float_a: assert property (syncBus.csNS |-> !sdioOe && !serialDataOutPinOe)
        else $error("outputs driven while deselected");
    select_suspend_a: assert property (syncBus.csNS && !syncBus.ioResetS
        |=> $stable(core_reg.bitCnt) && $stable(core_reg.phase))
        else $error("cycle advanced while deselected");
    fall_drive_a: assert property (sclkFall && !syncBus.csNS && !syncBus.ioResetS
        && core_reg.phase == SCP_READ
        |=> core_reg.dataOut == $past(core_reg.readData[core_reg.readIdx]))
        else $error("read bit not driven on falling edge");
    write_capture_a: assert property (core_reg.phase == SCP_WRITE && !sclkRise
        |=> $stable(core_reg.shiftReg))
        else $error("data shifted without rising edge");
    cycle_end_a: assert property (sclkRise && !syncBus.csNS && !syncBus.ioResetS && byteDone
        && core_reg.phase != SCP_INSTR && core_reg.byteCnt == core_reg.lastByte
        |=> core_reg.phase == SCP_INSTR && core_reg.bitCnt == '0)
        else $error("cycle did not return to instruction");
    pin_mode_a: assert property (!(sdioOe && serialDataOutPinOe))
        else $error("both data outputs driven");

    write_seen_c: cover property (core_reg.phase == SCP_WRITE ##1 core_reg.phase == SCP_INSTR);
    read_seen_c: cover property (core_reg.phase == SCP_READ && sdioOe);
    abort_seen_c: cover property (core_reg.phase == SCP_WRITE && syncBus.ioResetS);
    commit_seen_c: cover property (commit && core_reg.active != core_reg.staging);
endmodule : scp_serial_config_port

// >>> verif/scp_host_model.sv
`timescale 1ns/100ps
module scp_host_model (
    input wire logic clk,
    output logic sclk,
    output logic csN,
    output logic sdioIn,
    input wire logic sdioOut,
    input wire logic sdioOe,
    input wire logic serialDataOutPinOut,
    input wire logic serialDataOutPinOe
);
    logic hostOe;
    logic hostBit;
    logic junk;
    logic lsbFirst;
    logic threeWire;
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        hostOe = 1'b0;
        hostBit = 1'b0;
        junk = 1'b0;
        lsbFirst = 1'b0;
        threeWire = 1'b0;
    end
    // ----------------------------------------
    // Data wire
    // ----------------------------------------
    // No pull on the pin, so a released line toggles rather than holding its last bit
    always @(posedge clk) junk <= ~junk;
    assign sdioIn = hostOe ? hostBit : (sdioOe ? sdioOut : junk);
    // ----------------------------------------
    // Serial master
    // ----------------------------------------
    task automatic sel(input logic level);
        @(negedge clk);
        csN = level;
    endtask : sel
    // Five clocks per serial phase, above the oversampling minimum
    task automatic shift(input logic [63:0] tx, input int nBits, input logic drive, output logic [63:0] rx);
        int k;
        int idx;
        rx = '0;
        for (k = 0; k < nBits; k++) begin
            idx = lsbFirst ? k : nBits - 1 - k;
            @(negedge clk);
            sclk = 1'b0;
            hostOe = drive;
            hostBit = tx[idx];
            repeat (5) @(negedge clk);
            rx[idx] = threeWire ? (serialDataOutPinOe ? serialDataOutPinOut : junk) : sdioIn;
            sclk = 1'b1;
            repeat (4) @(negedge clk);
        end
    endtask : shift
    task automatic frame(input logic [7:0] instr, input int nBits, input logic [63:0] tx, output logic [63:0] rx);
        logic [63:0] unused;
        sel(1'b0);
        shift(64'(instr), 8, 1'b1, unused);
        shift(tx, nBits, ~instr[7], rx);
        sel(1'b1);
    endtask : frame
endmodule : scp_host_model

// >>> verif/scp_serial_config_port_tb_top.sv
`timescale 1ns/100ps
module scp_serial_config_port_tb_top;
    typedef struct {
        logic [7:0] instr;
        logic [31:0] data;
    } scp_row_t;
    logic clk;
    logic rst;
    logic sclk;
    logic csN;
    logic sdioIn;
    logic sdioOut;
    logic sdioOe;
    logic sdoOut;
    logic sdoOe;
    logic ioReset;
    logic ioUpdate;
    logic [2:0] profile;
    logic [31:0] active;
    logic [63:0] rx;
    logic [63:0] hi;
    logic [63:0] prev;
    int err_total = 0;
    int checked = 0;
    scp_row_t rows [4] = '{'{8'h01, 32'hA5C3_0F1E}, '{8'h61, 32'h0000_0001},
                           '{8'h21, 32'h8000_0000}, '{8'h41, 32'hFFFF_FFFF}};
    scp_serial_config_port i_scp_serial_config_port (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN),
        .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe), .serialDataOutPinOut(sdoOut),
        .serialDataOutPinOe(sdoOe), .ioReset(ioReset), .ioUpdate(ioUpdate), .profile(profile),
        .activeControlFunctionTwo(active));
    scp_host_model i_scp_host_model (.clk(clk), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
        .sdioOut(sdioOut), .sdioOe(sdioOe), .serialDataOutPinOut(sdoOut), .serialDataOutPinOe(sdoOe));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [63:0] expv, input logic [63:0] got);
        checked++;
        if (got !== expv) begin
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
            err_total++;
        end
    endtask : chk
    task automatic pulse(input bit abort);
        @(negedge clk);
        if (abort) ioReset = 1'b1;
        else ioUpdate = 1'b1;
        repeat (3) @(negedge clk);
        ioReset = 1'b0;
        ioUpdate = 1'b0;
        repeat (4) @(negedge clk);
    endtask : pulse
    task automatic end_sim();
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        end_sim();
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        ioReset = 1'b0;
        ioUpdate = 1'b0;
        profile = 3'h0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("active after reset", '0, 64'(active));
        prev = '0;
        foreach (rows[i]) begin
            i_scp_host_model.frame(rows[i].instr, 32, 64'(rows[i].data), rx);
            chk("active before commit", prev, 64'(active));
            pulse(1'b0);
            chk("active after commit", 64'(rows[i].data), 64'(active));
            i_scp_host_model.frame(8'h80 | rows[i].instr, 32, '0, rx);
            chk("read back", 64'(rows[i].data), rx);
            prev = 64'(rows[i].data);
        end
        // Staged but uncommitted data must not show on a read
        i_scp_host_model.frame(8'h01, 32, 64'(32'h0BAD_F00D), rx);
        i_scp_host_model.frame(8'h81, 32, '0, rx);
        chk("read of staged", prev, rx);
        // Abort after two whole bytes and three bits of the third
        i_scp_host_model.frame(8'h01, 19, 64'(32'h1234_5678 >> 13), rx);
        pulse(1'b1);
        pulse(1'b0);
        chk("active after abort", 64'(32'h1234_F00D), 64'(active));
        i_scp_host_model.frame(8'h01, 32, 64'(32'hCAFE_0001), rx);
        @(negedge clk);
        profile = 3'h5;
        repeat (6) @(negedge clk);
        chk("profile commit", 64'(32'hCAFE_0001), 64'(active));
        // Deselect in mid read, clocking driven ones while deselected
        i_scp_host_model.sel(1'b0);
        i_scp_host_model.shift(64'(8'h81), 8, 1'b1, rx);
        i_scp_host_model.shift('0, 16, 1'b0, hi);
        i_scp_host_model.sel(1'b1);
        i_scp_host_model.shift('1, 8, 1'b1, rx);
        chk("drive while deselected", '0, 64'({sdioOe, sdoOe}));
        i_scp_host_model.sel(1'b0);
        i_scp_host_model.shift('0, 16, 1'b0, rx);
        i_scp_host_model.sel(1'b1);
        chk("suspended read", 64'(32'hCAFE_0001), 64'({hi[15:0], rx[15:0]}));
        // Profile write with other pins, read with matching pins
        i_scp_host_model.frame(8'h15, 64, 64'h0123_4567_89AB_CDEF, rx);
        pulse(1'b0);
        @(negedge clk);
        profile = 3'h7;
        repeat (6) @(negedge clk);
        i_scp_host_model.frame(8'h95, 64, '0, rx);
        chk("profile read", 64'h0123_4567_89AB_CDEF, rx);
        // Three-wire, least significant bit first
        i_scp_host_model.frame(8'h00, 32, 64'(32'h0000_0003), rx);
        pulse(1'b0);
        i_scp_host_model.lsbFirst = 1'b1;
        i_scp_host_model.threeWire = 1'b1;
        i_scp_host_model.frame(8'h81, 32, '0, rx);
        chk("three wire read", 64'(32'hCAFE_0001), rx);
        i_scp_host_model.frame(8'h01, 32, 64'(32'h1357_9BDF), rx);
        pulse(1'b0);
        chk("lsb first write", 64'(32'h1357_9BDF), 64'(active));
        i_scp_host_model.frame(8'h81, 32, '0, rx);
        chk("three wire read back", 64'(32'h1357_9BDF), rx);
        end_sim();
    end
endmodule : scp_serial_config_port_tb_top
